/* amp_config_regs.sv */
// amplifier configuration register bank with per-channel control outputs
// assumes a plain register port on sys_clk; read data one cycle later
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module amp_config_regs #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned N_CH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic bus_err,
  output logic [N_CH-1:0] amp_en,
  output logic [N_CH*3-1:0] amp_gain_sel,
  output logic [N_CH-1:0] amp_ext_mode,
  output logic [N_CH-1:0] amp_pin_gpio,
  output logic [N_CH*5-1:0] amp_gain_mult,
  output logic [N_CH-1:0] amp_changed,
  input wire logic [1:0] adc_sel,
  output logic adc_src_valid,
  output logic [4:0] adc_src_mult
);

  // elaboration checks
  if (ADDR_W < 6 || ADDR_W > 8) begin : gen_bad_addr
    $error("ADDR_W must lie between 6 and 8");
  end
  if (N_CH < 1 || N_CH > amp_pkg::AMP_NUM_CH) begin : gen_bad_ch
    $error("N_CH must lie between 1 and 4");
  end

  // address decode
  logic cfg_hit;
  logic wr_hit;
  logic rd_hit;
  logic acc_miss;

  always_comb begin
    cfg_hit = 1'b0;
    if (bus_addr == amp_pkg::AMP_CFG_OFFSET[ADDR_W-1:0]) begin
      cfg_hit = 1'b1;
    end else begin
      cfg_hit = 1'b0;
    end
  end

  assign wr_hit = bus_wr && cfg_hit;
  assign rd_hit = bus_rd && cfg_hit;
  assign acc_miss = (bus_wr || bus_rd) && !cfg_hit;

  // writable bit mask limited to the channels built
  logic [31:0] live_mask;

  always_comb begin
    live_mask = '0;
    for (int i = 0; i < N_CH; i++) begin
      live_mask[amp_pkg::AMP_EN_POS[i]] = 1'b1;
      live_mask[amp_pkg::AMP_GAIN_LSB[i] +: 3] = 3'h7;
    end
    live_mask = live_mask & amp_pkg::AMP_CFG_WMASK;
  end

  // configuration register
  logic [31:0] cfg_q, cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_hit) begin
      cfg_d = bus_wdata & live_mask;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= amp_pkg::AMP_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // read data and unmapped access flag
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_hit) begin
      rdata_d = cfg_q & live_mask;
    end
    err_d = acc_miss;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_err = err_q;

  // field extraction per channel
  logic [N_CH-1:0] fld_en;
  logic [N_CH*3-1:0] fld_gain;

  always_comb begin
    fld_en = '0;
    fld_gain = '0;
    for (int i = 0; i < N_CH; i++) begin
      // channel one bit 0, two bit 8, three bit 16
      fld_en[i] = cfg_q[amp_pkg::AMP_EN_POS[i]];
      // channel one bits 4:2, two bits 12:10
      fld_gain[i*3 +: 3] = cfg_q[amp_pkg::AMP_GAIN_LSB[i] +: 3];
    end
  end

  assign amp_gain_sel = fld_gain;

  // independent decoder per channel
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : gen_ch
      amp_chan_decode u_dec (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cfg_en(fld_en[g]),
        .cfg_gain(fld_gain[g*3 +: 3]),
        .ch_en(amp_en[g]),
        .ch_ext_mode(amp_ext_mode[g]),
        .ch_pin_gpio(amp_pin_gpio[g]),
        .ch_mult(amp_gain_mult[g*5 +: 5]),
        .ch_changed(amp_changed[g])
      );
    end
  endgenerate

  // converter source selection
  amp_adc_src #(
    .N_CH(N_CH)
  ) u_adc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .adc_sel(adc_sel),
    .ch_en(amp_en),
    .ch_mult(amp_gain_mult),
    .src_valid(adc_src_valid),
    .src_mult(adc_src_mult)
  );

endmodule

/* amp_pkg.sv */
// constants for the amplifier configuration register bank
// assumes a single 250 MHz system clock and a plain register port
package amp_pkg;

  localparam int unsigned AMP_NUM_CH = 4;
  localparam int unsigned AMP_GAIN_W = 3;
  localparam int unsigned AMP_MULT_W = 5;
  localparam int unsigned AMP_DATA_W = 32;
  localparam int unsigned AMP_SEL_W = 2;

  localparam logic [7:0] AMP_CFG_OFFSET = 8'h34;
  localparam logic [31:0] AMP_CFG_RESET = 32'h0000_0000;

  localparam int unsigned AMP_EN_POS [AMP_NUM_CH] = '{0, 8, 16, 24};
  localparam int unsigned AMP_GAIN_LSB [AMP_NUM_CH] = '{2, 10, 18, 26};

  localparam logic [31:0] AMP_CFG_WMASK = 32'h1d1d_1d1d;

  localparam logic [2:0] AMP_GAIN_EXT = 3'h0;
  localparam logic [2:0] AMP_GAIN_X1 = 3'h1;
  localparam logic [2:0] AMP_GAIN_X2 = 3'h2;
  localparam logic [2:0] AMP_GAIN_X4 = 3'h3;
  localparam logic [2:0] AMP_GAIN_X8 = 3'h4;
  localparam logic [2:0] AMP_GAIN_X10 = 3'h5;
  localparam logic [2:0] AMP_GAIN_X16 = 3'h6;
  localparam logic [2:0] AMP_GAIN_X20 = 3'h7;

  localparam logic [4:0] AMP_MULT_EXT = 5'h00;
  localparam logic [4:0] AMP_MULT_X1 = 5'h01;
  localparam logic [4:0] AMP_MULT_X2 = 5'h02;
  localparam logic [4:0] AMP_MULT_X4 = 5'h04;
  localparam logic [4:0] AMP_MULT_X8 = 5'h08;
  localparam logic [4:0] AMP_MULT_X10 = 5'h0a;
  localparam logic [4:0] AMP_MULT_X16 = 5'h10;
  localparam logic [4:0] AMP_MULT_X20 = 5'h14;

  function automatic logic [4:0] gain_to_mult(input logic [2:0] code);
    logic [4:0] m;
    m = AMP_MULT_EXT;
    case (code)
      AMP_GAIN_X1: m = AMP_MULT_X1;
      AMP_GAIN_X2: m = AMP_MULT_X2;
      AMP_GAIN_X4: m = AMP_MULT_X4;
      AMP_GAIN_X8: m = AMP_MULT_X8;
      AMP_GAIN_X10: m = AMP_MULT_X10;
      AMP_GAIN_X16: m = AMP_MULT_X16;
      AMP_GAIN_X20: m = AMP_MULT_X20;
      default: m = AMP_MULT_EXT;
    endcase
    return m;
  endfunction

endpackage

/* amp_chan_decode.sv */
// one amplifier channel: turns enable and gain code into control levels
// assumes its inputs come from registers on the same clock
`timescale 1ns/10ps
module amp_chan_decode (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_en,
  input wire logic [2:0] cfg_gain,
  output logic ch_en,
  output logic ch_ext_mode,
  output logic ch_pin_gpio,
  output logic [4:0] ch_mult,
  output logic ch_changed
);

  logic en_q, en_d;
  logic ext_q, ext_d;
  logic gpio_q, gpio_d;
  logic [4:0] mult_q, mult_d;
  logic chg_q, chg_d;

  always_comb begin
    en_d = cfg_en;
    ext_d = (cfg_gain == amp_pkg::AMP_GAIN_EXT);
    gpio_d = (cfg_gain != amp_pkg::AMP_GAIN_EXT);
    mult_d = amp_pkg::gain_to_mult(cfg_gain);
    chg_d = (en_d != en_q) || (mult_d != mult_q) || (ext_d != ext_q);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      ext_q <= 1'b1;
      gpio_q <= 1'b0;
      mult_q <= amp_pkg::AMP_MULT_EXT;
      chg_q <= 1'b0;
    end else begin
      en_q <= en_d;
      ext_q <= ext_d;
      gpio_q <= gpio_d;
      mult_q <= mult_d;
      chg_q <= chg_d;
    end
  end

  assign ch_en = en_q;
  assign ch_ext_mode = ext_q;
  assign ch_pin_gpio = gpio_q;
  assign ch_mult = mult_q;
  assign ch_changed = chg_q;

endmodule

/* amp_adc_src.sv */
// picks one amplifier output as the converter input source
// assumes select and channel state come from the same clock
`timescale 1ns/10ps
module amp_adc_src #(
  parameter int unsigned N_CH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] adc_sel,
  input wire logic [N_CH-1:0] ch_en,
  input wire logic [N_CH*5-1:0] ch_mult,
  output logic src_valid,
  output logic [4:0] src_mult
);

  // a two-bit select cannot reach more than four channels
  if (N_CH < 1 || N_CH > 4) begin : gen_bad_ch
    $error("N_CH must lie between 1 and 4");
  end

  logic valid_q, valid_d;
  logic [4:0] mult_q, mult_d;

  always_comb begin
    valid_d = 1'b0;
    mult_d = amp_pkg::AMP_MULT_EXT;
    for (int i = 0; i < N_CH; i++) begin
      if (adc_sel == i[1:0]) begin
        valid_d = ch_en[i];
        mult_d = ch_mult[i*5 +: 5];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      mult_q <= amp_pkg::AMP_MULT_EXT;
    end else begin
      valid_q <= valid_d;
      mult_q <= mult_d;
    end
  end

  assign src_valid = valid_q;
  assign src_mult = mult_q;

endmodule

/* amp_config_regs_props.sv */
// checker for the amplifier configuration register bank
// assumes it is bound to amp_config_regs on one clock
`timescale 1ns/10ps
module amp_config_regs_props #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned N_CH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_err,
  input wire logic [N_CH-1:0] amp_en,
  input wire logic [N_CH*3-1:0] amp_gain_sel,
  input wire logic [N_CH-1:0] amp_ext_mode,
  input wire logic [N_CH-1:0] amp_pin_gpio,
  input wire logic [N_CH-1:0] amp_changed,
  input wire logic [1:0] adc_sel,
  input wire logic adc_src_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic miss;
  assign miss = (bus_wr || bus_rd) && bus_addr != 8'h34;
  sequence cfg_wr;
    bus_wr && bus_addr == 8'h34;
  endsequence
  gain_load_a: assert property (cfg_wr |=> amp_gain_sel[2:0] == $past(bus_wdata[4:2]))
    else $error("gain load");
  en_load_a: assert property (cfg_wr |-> ##2 amp_en[0] == $past(bus_wdata[0], 2))
    else $error("enable load");
  err_set_a: assert property (miss |=> bus_err)
    else $error("no error pulse");
  err_clr_a: assert property (!miss |=> !bus_err)
    else $error("stray error");
  rsvd_read_a: assert property ((bus_rdata & 32'he2e2_e2e2) == 32'h0)
    else $error("reserved bit set");
  ext_mode_a: assert property (amp_ext_mode[0] == ($past(amp_gain_sel[2:0]) == 3'h0))
    else $error("ext mode");
  pin_free_a: assert property (amp_pin_gpio[1] == ($past(amp_gain_sel[5:3]) != 3'h0))
    else $error("pin release");
  src_valid_a: assert property (adc_sel == 2'h0 |=> adc_src_valid == $past(amp_en[0]))
    else $error("source valid");
  chan_change_a: assert property ($rose(amp_en[0]) |-> amp_changed[0])
    else $error("change pulse");
endmodule
bind amp_config_regs amp_config_regs_props #(
  .ADDR_W(ADDR_W),
  .N_CH(N_CH)
) u_props (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_wr(bus_wr),
  .bus_rd(bus_rd),
  .bus_rdata(bus_rdata),
  .bus_err(bus_err),
  .amp_en(amp_en),
  .amp_gain_sel(amp_gain_sel),
  .amp_ext_mode(amp_ext_mode),
  .amp_pin_gpio(amp_pin_gpio),
  .amp_changed(amp_changed),
  .adc_sel(adc_sel),
  .adc_src_valid(adc_src_valid)
);

/* amp_config_regs_tb.sv */
// testbench for the amplifier configuration register bank
// assumes amp_pkg, the design and its checker are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module amp_config_regs_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic [1:0] adc_sel = 2'h0;
  logic [31:0] bus_rdata;
  logic bus_err;
  logic adc_src_valid;
  logic [3:0] amp_en, amp_ext_mode, amp_pin_gpio, amp_changed;
  logic [11:0] amp_gain_sel;
  logic [19:0] amp_gain_mult;
  logic [4:0] adc_src_mult;
  logic [4:0] ml [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h10, 5'h14};
  logic [5:0] adc_ex [4] = '{6'h21, 6'h04, 6'h2a, 6'h34};
  int mismatches = 0;
  int check_count = 0;
  amp_config_regs uut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .bus_err(bus_err),
    .amp_en(amp_en),
    .amp_gain_sel(amp_gain_sel),
    .amp_ext_mode(amp_ext_mode),
    .amp_pin_gpio(amp_pin_gpio),
    .amp_gain_mult(amp_gain_mult),
    .amp_changed(amp_changed),
    .adc_sel(adc_sel),
    .adc_src_valid(adc_src_valid),
    .adc_src_mult(adc_src_mult)
  );
  initial forever #2 sys_clk = ~sys_clk;
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
  endtask
  task t_reset;
    `CHK(amp_ext_mode, 4'hf)
    `CHK(adc_src_valid, 1'b0)
    `CHK(amp_en, 4'h0)
    `CHK(amp_gain_mult, 20'h0)
    `CHK(amp_pin_gpio, 4'h0)
    `CHK(bus_err, 1'b0)
    rd(8'h34, 32'h0);
  endtask
  task t_gain;
    logic [2:0] g;
    for (int c = 0; c < 8; c++) begin
      g = c[2:0];
      wr(8'h34, {19'h0, g, 2'h1, 3'h0, g, 2'h1});
      @(posedge sys_clk);
      #1;
      `CHK(amp_gain_sel[5:0], ({g, g}))
      `CHK(amp_gain_mult[9:0], ({ml[g], ml[g]}))
      `CHK(amp_ext_mode[1:0], ({2{g == 3'h0}}))
      `CHK(amp_pin_gpio[1:0], ({2{g != 3'h0}}))
      `CHK(amp_en[1:0], 2'h3)
      `CHK(amp_changed, 4'h3)
    end
    wr(8'h34, 32'h0);
    @(posedge sys_clk);
    #1;
    `CHK(amp_en, 4'h0)
    `CHK(amp_changed, 4'h3)
    @(posedge sys_clk);
    #1;
    `CHK(amp_changed, 4'h0)
  endtask
  task t_rsvd;
    wr(8'h34, 32'hffff_ffff);
    rd(8'h34, 32'h1d1d_1d1d);
    `CHK(amp_en, 4'hf)
    `CHK(amp_gain_sel, 12'hfff)
    `CHK(amp_gain_mult, 20'ha5294)
    `CHK(amp_pin_gpio, 4'hf)
    `CHK(amp_ext_mode, 4'h0)
  endtask
  task t_unmap;
    wr(8'h30, 32'h0);
    #1;
    `CHK(bus_err, 1'b1)
    rd(8'h30, 32'h0);
    `CHK(bus_err, 1'b1)
    rd(8'h34, 32'h1d1d_1d1d);
    `CHK(bus_err, 1'b0)
  endtask
  task t_adc;
    wr(8'h34, 32'h1d15_0c05);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      adc_sel <= s[1:0];
      @(posedge sys_clk);
      #1;
      `CHK(({adc_src_valid, adc_src_mult}), adc_ex[s])
    end
  endtask
  task t_mid_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(amp_en, 4'h0)
    `CHK(amp_gain_sel, 12'h000)
    `CHK(amp_ext_mode, 4'hf)
    `CHK(adc_src_valid, 1'b0)
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h34, 32'h0);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_gain;
    t_rsvd;
    t_unmap;
    t_adc;
    t_mid_reset;
    complete_run;
  end
endmodule
